// ---- rtl/byte_fifo.sv ----
// first-word-fall-through fifo with registered flags and level
// assumes the user keeps push data stable while push_valid is high
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  fifo_port_if.fifo port
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic not_empty;
  logic not_full;
  logic do_push;
  logic do_pop;
  logic [CW-1:0] next_count;
  logic [AW-1:0] next_rd;
  logic [WIDTH-1:0] head;
  logic head_from_push;

  assign do_push = port.push_valid && not_full && !port.flush;
  assign do_pop = port.pop_ready && not_empty && !port.flush;
  assign port.push_ready = not_full;
  assign port.pop_valid = not_empty;
  assign port.pop_data = head;
  assign port.count = count;
  assign next_rd = !do_pop ? rd_ptr :
    (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
  // with nothing left after the pop, the pushed word becomes the head
  assign head_from_push = (count == CW'(do_pop));

  // the front word is held in a register so the read side sees a flop
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      head <= '0;
    end else if (head_from_push) begin
      head <= port.push_data;
    end else begin
      head <= mem[next_rd];
    end
  end

  always_comb begin
    next_count = count;
    if (do_push && !do_pop) begin
      next_count = count + CW'(1);
    end else if (do_pop && !do_push) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= port.push_data;
    end
  end

  // flush drops every stored word in one cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || port.flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      not_empty <= 1'b0;
      not_full <= 1'b1;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= next_count;
      not_empty <= (next_count != '0);
      not_full <= (next_count != CW'(DEPTH));
    end
  end
endmodule // byte_fifo

// ---- rtl/fifo_port_if.sv ----
// push, pop, flush and fill level of one byte fifo
// assumes one clock domain shared by both ends
`timescale 1ns/1ns
interface fifo_port_if #(parameter int WIDTH = 8, parameter int CW = 4);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic flush;
  logic [CW-1:0] count;
  modport fifo (input push_valid, push_data, pop_ready, flush,
    output push_ready, pop_valid, pop_data, count);
  modport user (output push_valid, push_data, pop_ready, flush,
    input push_ready, pop_valid, pop_data, count);
endinterface // fifo_port_if

// ---- rtl/sd_resp_pkg.sv ----
// constants, field layout and state type for the response capture block
// assumes a 32-bit classic wishbone slave on the byte-address map below
// Functional notes
// - six-bit read-only index of last response
// - index reads all ones after or
// - short status responses fill only word0 card status
// - long response bits split over four words
// - writing bit 31 empties receive fifo
// - writing bit 30 empties transmit fifo
// - eight-bit receive fifo byte count, read-only
// - eight-bit transmit fifo free space, read-only
// - fifo status reads 0x80 after reset
package sd_resp_pkg;
  localparam logic [7:0] OFF_INDEX = 8'h20;
  localparam logic [7:0] OFF_WORD0 = 8'h24;
  localparam logic [7:0] OFF_WORD1 = 8'h28;
  localparam logic [7:0] OFF_WORD2 = 8'h2c;
  localparam logic [7:0] OFF_WORD3 = 8'h30;
  localparam logic [7:0] OFF_FIFO = 8'h34;
  localparam int FLUSH_RX_BIT = 31;
  localparam int FLUSH_TX_BIT = 30;
  localparam int RX_CNT_LSB = 8;
  localparam int TX_CNT_LSB = 0;
  localparam logic [31:0] FIFO_STATUS_RESET = 32'h0000_0080;
  localparam logic [2:0] RESP_R1_R6 = 3'h0;
  localparam logic [2:0] RESP_R1B = 3'h1;
  localparam logic [2:0] RESP_R2 = 3'h2;
  localparam logic [2:0] RESP_R3_R4 = 3'h3;
  localparam logic [2:0] RESP_NONE = 3'h4;
  localparam logic [5:0] INDEX_ALL_ONES = 6'h3f;
  localparam int SHORT_BITS = 48;
  localparam int LONG_BITS = 136;
  localparam int INDEX_LSB = 40;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_WAIT_START = 2'b01,
    RX_SHIFT = 2'b11
  } rx_state_t;
endpackage

// ---- rtl/sd_response_capture.sv ----
// response capture from the card command line, response registers,
// fifo level and flush register behind a classic wishbone slave
// assumes the card clock and command line arrive unsynchronised
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ns
module sd_response_capture #(
  parameter int RX_DEPTH = 8,
  parameter int TX_DEPTH = 128
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic resp_arm_i,
  input wire logic [2:0] resp_type_i,
  input wire logic sd_clk_i,
  input wire logic sd_cmd_i,
  output logic resp_done_o,
  input wire logic rx_in_valid_i,
  input wire logic [7:0] rx_in_data_i,
  output logic rx_in_ready_o,
  output logic rx_out_valid_o,
  output logic [7:0] rx_out_data_o,
  input wire logic rx_out_ready_i,
  input wire logic tx_in_valid_i,
  input wire logic [7:0] tx_in_data_i,
  output logic tx_in_ready_o,
  output logic tx_out_valid_o,
  output logic [7:0] tx_out_data_o,
  input wire logic tx_out_ready_i
);
  localparam int RX_CW = $clog2(RX_DEPTH + 1);
  localparam int TX_CW = $clog2(TX_DEPTH + 1);

  fifo_port_if #(.WIDTH(8), .CW(RX_CW)) rx_port ();
  fifo_port_if #(.WIDTH(8), .CW(TX_CW)) tx_port ();

  // card side synchronisers and edge finder
  logic clk_meta;
  logic clk_sync;
  logic clk_prev;
  logic cmd_meta;
  logic cmd_sync;
  logic sample_edge;

  // receiver
  sd_resp_pkg::rx_state_t rx_state;
  logic long_resp;
  logic [7:0] bits_left;
  logic [135:0] shift;
  logic [135:0] next_shift;
  logic commit;
  logic arm_ok;
  logic start_seen;
  logic shift_en;
  logic index_forced;

  // registers
  logic [5:0] resp_index;
  logic [31:0] word0;
  logic [31:0] word1;
  logic [31:0] word2;
  logic [23:0] word3;
  logic rx_flush;
  logic tx_flush;
  logic [31:0] status_word;
  logic [31:0] next_rdata;
  logic bus_req;
  logic bus_wr;
  logic flush_wr;

  // card clock: two flops, then a third one for the edge finder
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_prev <= 1'b0;
    end else begin
      clk_meta <= sd_clk_i;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
    end
  end

  // the command line idles high, so its flops reset high
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cmd_meta <= 1'b1;
      cmd_sync <= 1'b1;
    end else begin
      cmd_meta <= sd_cmd_i;
      cmd_sync <= cmd_meta;
    end
  end

  // the command line is sampled on each rising card clock edge
  assign sample_edge = clk_sync && !clk_prev;
  assign next_shift = {shift[134:0], cmd_sync};
  assign shift_en = (rx_state == sd_resp_pkg::RX_SHIFT) && sample_edge;
  assign commit = shift_en && (bits_left == 8'h01);
  assign arm_ok = (rx_state == sd_resp_pkg::RX_IDLE) && resp_arm_i &&
    resp_type_i != sd_resp_pkg::RESP_NONE &&
    resp_type_i <= sd_resp_pkg::RESP_R3_R4;
  assign start_seen = (rx_state == sd_resp_pkg::RX_WAIT_START) &&
    sample_edge && !cmd_sync;

  // frame receiver: armed, waiting for the start bit, shifting
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_state <= sd_resp_pkg::RX_IDLE;
    end else begin
      case (rx_state)
        sd_resp_pkg::RX_IDLE: begin
          if (arm_ok) begin
            rx_state <= sd_resp_pkg::RX_WAIT_START;
          end
        end
        sd_resp_pkg::RX_WAIT_START: begin
          if (start_seen) begin
            rx_state <= sd_resp_pkg::RX_SHIFT;
          end
        end
        sd_resp_pkg::RX_SHIFT: begin
          if (commit) begin
            rx_state <= sd_resp_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_state <= sd_resp_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // the declared type is kept from arming, so its input may move on
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      long_resp <= 1'b0;
      index_forced <= 1'b0;
    end else if (arm_ok) begin
      long_resp <= (resp_type_i == sd_resp_pkg::RESP_R2);
      index_forced <= (resp_type_i == sd_resp_pkg::RESP_R2) ||
        (resp_type_i == sd_resp_pkg::RESP_R3_R4);
    end
  end

  // frame length counts down from the start bit
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      bits_left <= 8'h00;
    end else if (start_seen) begin
      bits_left <= long_resp ? 8'(sd_resp_pkg::LONG_BITS - 1) :
        8'(sd_resp_pkg::SHORT_BITS - 1);
    end else if (shift_en) begin
      bits_left <= bits_left - 8'h01;
    end
  end

  // the start bit is not kept; later bits enter at the bottom
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || start_seen) begin
      shift <= '0;
    end else if (shift_en) begin
      shift <= next_shift;
    end
  end

  // every response register loads on the commit edge and no other
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      resp_index <= 6'h00;
    end else if (commit) begin
      if (index_forced) begin
        resp_index <= sd_resp_pkg::INDEX_ALL_ONES;
      end else begin
        resp_index <= next_shift[sd_resp_pkg::INDEX_LSB +: 6];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      word0 <= 32'h0000_0000;
    end else if (commit) begin
      word0 <= next_shift[39:8];
    end
  end

  // short frames clear the long-only words so no stale field remains
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      word1 <= 32'h0000_0000;
      word2 <= 32'h0000_0000;
      word3 <= 24'h00_0000;
    end else if (commit) begin
      if (long_resp) begin
        word1 <= next_shift[71:40];
        word2 <= next_shift[103:72];
        word3 <= next_shift[127:104];
      end else begin
        word1 <= 32'h0000_0000;
        word2 <= 32'h0000_0000;
        word3 <= 24'h00_0000;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      resp_done_o <= 1'b0;
    end else begin
      resp_done_o <= commit;
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .port(rx_port.fifo)
  );

  byte_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .port(tx_port.fifo)
  );

  assign rx_port.push_valid = rx_in_valid_i;
  assign rx_port.push_data = rx_in_data_i;
  assign rx_port.pop_ready = rx_out_ready_i;
  assign rx_port.flush = rx_flush;
  assign tx_port.push_valid = tx_in_valid_i;
  assign tx_port.push_data = tx_in_data_i;
  assign tx_port.pop_ready = tx_out_ready_i;
  assign tx_port.flush = tx_flush;
  assign rx_in_ready_o = rx_port.push_ready;
  assign rx_out_valid_o = rx_port.pop_valid;
  assign rx_out_data_o = rx_port.pop_data;
  assign tx_in_ready_o = tx_port.push_ready;
  assign tx_out_valid_o = tx_port.pop_valid;
  assign tx_out_data_o = tx_port.pop_data;

  // wishbone: one wait state, ack for one cycle, unmapped reads zero
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i;

  // flush bits read back as zero and only pulse the fifo
  assign flush_wr = bus_wr && wb_adr_i == sd_resp_pkg::OFF_FIFO &&
    wb_sel_i[3];

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_flush <= 1'b0;
    end else begin
      rx_flush <= flush_wr && wb_dat_i[sd_resp_pkg::FLUSH_RX_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx_flush <= 1'b0;
    end else begin
      tx_flush <= flush_wr && wb_dat_i[sd_resp_pkg::FLUSH_TX_BIT];
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[sd_resp_pkg::RX_CNT_LSB +: 8] = 8'(rx_port.count);
    status_word[sd_resp_pkg::TX_CNT_LSB +: 8] =
      8'(TX_DEPTH - int'(tx_port.count));
  end

  always_comb begin
    case (wb_adr_i)
      sd_resp_pkg::OFF_INDEX: next_rdata = {26'h0, resp_index};
      sd_resp_pkg::OFF_WORD0: next_rdata = word0;
      sd_resp_pkg::OFF_WORD1: next_rdata = word1;
      sd_resp_pkg::OFF_WORD2: next_rdata = word2;
      sd_resp_pkg::OFF_WORD3: next_rdata = {8'h00, word3};
      sd_resp_pkg::OFF_FIFO: next_rdata = status_word;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // read data stays until the next read
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end
endmodule // sd_response_capture

// ---- testbench/sd_card_model.sv ----
// behavioural card sending response frames on the command line
// assumes the host samples the line on rising card clock edges
`timescale 1ns/1ns
module sd_card_model (
  output logic sd_clk_o,
  output logic sd_cmd_o
);
  initial begin
    sd_clk_o = 1'b0;
    sd_cmd_o = 1'b1;
  end
  // clock stands still between frames, line rests at its pull-up level
  task automatic send(input logic [135:0] frame, input int bits);
    #37;
    for (int i = bits - 1; i >= 0; i--) begin
      sd_cmd_o = frame[i];
      #400 sd_clk_o = 1'b1;
      #400 sd_clk_o = 1'b0;
    end
    sd_cmd_o = 1'b1;
  endtask
endmodule // sd_card_model

// ---- testbench/sd_response_capture_bench.sv ----
// bench for the response capture block with a card model on the link
// assumes wishbone answers within a few cycles of the request
`timescale 1ns/1ns
module sd_response_capture_bench;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0, wb_we_i = 1'b0, resp_arm_i = 1'b0;
  logic rx_in_valid_i = 1'b0, rx_out_ready_i = 1'b0;
  logic tx_in_valid_i = 1'b0, tx_out_ready_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0, rx_in_data_i = 8'h0, tx_in_data_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [2:0] resp_type_i = 3'h4;
  logic sd_clk_i, sd_cmd_i, wb_ack_o, resp_done_o, rx_in_ready_o;
  logic rx_out_valid_o, tx_in_ready_o, tx_out_valid_o;
  logic [31:0] wb_dat_o, e_w0;
  logic [7:0] rx_out_data_o, tx_out_data_o;
  logic [5:0] e_idx;
  int failures = 0;
  int check_count = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  sd_response_capture sd_response_capture_inst (.ref_clk_i, .rst_n_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .resp_arm_i, .resp_type_i, .sd_clk_i, .sd_cmd_i,
    .resp_done_o, .rx_in_valid_i, .rx_in_data_i, .rx_in_ready_o,
    .rx_out_valid_o, .rx_out_data_o, .rx_out_ready_i, .tx_in_valid_i,
    .tx_in_data_i, .tx_in_ready_o, .tx_out_valid_o, .tx_out_data_o,
    .tx_out_ready_i);
  sd_card_model sd_card_model_inst (.sd_clk_o(sd_clk_i),
    .sd_cmd_o(sd_cmd_i));
  task automatic chk(input string s, input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk_i);
    if (n >= 50) begin
      failures++;
      end_sim;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task automatic resp(input logic [2:0] ty, input logic [135:0] f,
      input int n, output bit seen);
    resp_type_i <= ty;
    resp_arm_i <= 1'b1;
    @(posedge ref_clk_i);
    resp_arm_i <= 1'b0;
    seen = 0;
    fork
      sd_card_model_inst.send(f, n);
      for (int k = 0; k < 1200 && !seen; k++) begin
        @(posedge ref_clk_i);
        seen = resp_done_o === 1'b1;
      end
    join
    @(posedge ref_clk_i);
  endtask
  task automatic t_reset;
    logic [31:0] q;
    for (int a = 32; a <= 48; a += 4) rdc(8'(a), 32'h0);
    rdc(8'h34, 32'h80);
    wb(1'b1, 8'h24, 32'hffff_ffff, q);
    rdc(8'h24, 32'h0);
    rdc(8'h38, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_long;
    logic [127:0] b;
    bit seen;
    b = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3211;
    resp(3'h2, {2'b00, 6'h2a, b}, 136, seen);
    chk("done", seen, 1);
    e_idx = 6'h3f;
    e_w0 = b[39:8];
    rdc(8'h20, 32'h3f);
    rdc(8'h24, e_w0);
    rdc(8'h28, b[71:40]);
    rdc(8'h2c, b[103:72]);
    rdc(8'h30, {8'h0, b[127:104]});
    $display("long test done");
  endtask
  task automatic t_short;
    logic [2:0] ty [4];
    logic [5:0] idx;
    logic [31:0] st;
    bit seen;
    ty = '{3'h4, 3'h0, 3'h1, 3'h3};
    for (int i = 0; i < 4; i++) begin
      idx = 6'(i + 17);
      st = {24'hc0ffee, 8'(i)};
      resp(ty[i], {88'h0, 2'b00, idx, st, 8'h01}, 48, seen);
      chk("done", seen, ty[i] != 3'h4);
      if (ty[i] != 3'h4) begin
        e_idx = ty[i] == 3'h3 ? 6'h3f : idx;
        e_w0 = st;
      end
      rdc(8'h20, {26'h0, e_idx});
      rdc(8'h24, e_w0);
      if (ty[i] != 3'h4) rdc(8'h28, 32'h0);
    end
    $display("short test done");
  endtask
  task automatic t_fifo;
    logic [31:0] q;
    int n;
    n = 0;
    for (int i = 0; i < 10; i++) begin
      rx_in_valid_i <= 1'b1;
      rx_in_data_i <= 8'(i);
      tx_in_valid_i <= i < 3;
      tx_in_data_i <= 8'(i + 64);
      @(posedge ref_clk_i);
      n += rx_in_ready_o === 1'b1;
    end
    rx_in_valid_i <= 1'b0;
    tx_in_valid_i <= 1'b0;
    chk("rx pushed", n, 8);
    rx_out_ready_i <= 1'b1;
    tx_out_ready_i <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk_i);
      chk("rx pop", rx_out_data_o, i);
      chk("tx pop", tx_out_data_o, i + 64);
    end
    rx_out_ready_i <= 1'b0;
    tx_out_ready_i <= 1'b0;
    rdc(8'h34, 32'h067f);
    chk("rx valid", rx_out_valid_o, 1);
    wb(1'b1, 8'h34, 32'h8000_0000, q);
    rdc(8'h34, 32'h007f);
    chk("rx valid", rx_out_valid_o, 0);
    chk("tx valid", tx_out_valid_o, 1);
    wb(1'b1, 8'h34, 32'h4000_0000, q);
    rdc(8'h34, 32'h0080);
    chk("tx valid", tx_out_valid_o, 0);
    chk("tx ready", tx_in_ready_o, 1);
    $display("fifo test done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_long;
    t_short;
    t_fifo;
    end_sim;
  end
endmodule // sd_response_capture_bench

// ---- testbench/sd_response_capture_properties.sv ----
// checker for the capture block's register and fifo ports
// assumes it is bound into every instance of the capture block
`timescale 1ns/1ns
module sd_capture_checker #(
  parameter int RX_DEPTH = 8,
  parameter int TX_DEPTH = 128
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [2:0] resp_type_i,
  input wire logic resp_done_o,
  input wire logic rx_out_valid_o,
  input wire logic tx_out_valid_o,
  input wire logic tx_in_ready_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [2:0] last_type;
  logic rd;
  logic wr;
  assign rd = wb_ack_o && !wb_we_i;
  assign wr = wb_ack_o && wb_we_i && wb_adr_i == 8'h34 && wb_sel_i[3];
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) last_type <= 3'h0;
    else if (resp_done_o) last_type <= resp_type_i;
  end
  property p_idx;
    rd && wb_adr_i == 8'h20 |-> wb_dat_o[31:6] == 26'h0;
  endproperty
  a_idx: assert property (p_idx) else $error("index wide");
  property p_ones;
    rd && wb_adr_i == 8'h20 && last_type inside {3'h2, 3'h3}
      |-> wb_dat_o[5:0] == 6'h3f;
  endproperty
  a_ones: assert property (p_ones) else $error("index not ones");
  property p_clr;
    rd && wb_adr_i inside {8'h28, 8'h2c, 8'h30} && last_type < 3'h2
      |-> wb_dat_o == 32'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("word not clear");
  property p_w3;
    rd && wb_adr_i == 8'h30 |-> wb_dat_o[31:24] == 8'h0;
  endproperty
  a_w3: assert property (p_w3) else $error("word3 top set");
  property p_wo;
    rd && wb_adr_i == 8'h34 |-> wb_dat_o[31:16] == 16'h0;
  endproperty
  a_wo: assert property (p_wo) else $error("flush bits read");
  property p_rxf;
    wr && wb_dat_i[31] |-> ##[1:2] !rx_out_valid_o;
  endproperty
  a_rxf: assert property (p_rxf) else $error("rx not flushed");
  property p_txf;
    wr && wb_dat_i[30] |-> ##[1:2] !tx_out_valid_o && tx_in_ready_o;
  endproperty
  a_txf: assert property (p_txf) else $error("tx not flushed");
  property p_cnt;
    rd && wb_adr_i == 8'h34
      |-> wb_dat_o[15:8] <= RX_DEPTH && wb_dat_o[7:0] <= TX_DEPTH;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count range");
  c_long: cover property (resp_done_o && resp_type_i == 3'h2);
  c_rxf: cover property (wr && wb_dat_i[31]);
  c_txf: cover property (wr && wb_dat_i[30]);
endmodule // sd_capture_checker
bind sd_response_capture sd_capture_checker #(.RX_DEPTH(RX_DEPTH),
  .TX_DEPTH(TX_DEPTH)) sd_capture_checker_inst (.ref_clk_i, .rst_n_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .resp_type_i, .resp_done_o, .rx_out_valid_o, .tx_out_valid_o,
  .tx_in_ready_o);
